// *** include/dbl_pkg.sv ***
// Package for the burst order and latency mode-register block
`default_nettype none
package dbl_pkg;
  // Register addresses
  localparam logic [5:0] ADDR_LATENCY_CONFIG = 6'h02;
  localparam logic [5:0] ADDR_IO_CONFIG = 6'h03;
  localparam logic [5:0] ADDR_TEMPERATURE_REFRESH = 6'h04;
  // Reset values
  localparam logic [7:0] LATENCY_CONFIG_RESET = 8'h00;
  localparam logic [7:0] IO_CONFIG_RESET = 8'h31;
  // Field positions
  localparam int RL_LSB = 0;
  localparam int WL_LSB = 3;
  localparam int WLS_BIT = 6;
  localparam int WRLEV_BIT = 7;
  localparam int PUCAL_BIT = 0;
  localparam int WRPST_BIT = 1;
  localparam int PROT_BIT = 2;
  localparam int PULLDOWN_DRIVE_STRENGTH_LSB = 3;
  localparam int RDBI_BIT = 6;
  localparam int WDBI_BIT = 7;
  localparam int TR_RATE_LSB = 0;
  localparam int TR_WR_LSB = 3;
  localparam int TR_WR_MSB = 6;
  localparam int TR_REPAIR_BIT = 4;
  localparam int TR_TUF_BIT = 7;
  localparam logic [7:0] TR_WRITE_MASK = 8'h78;
  // Latency tables indexed by code, 8 bits per entry, entry 0 at the low end
  localparam logic [63:0] RL_TABLE_PLAIN = 64'h24_20_1c_18_14_0e_0a_06;
  localparam logic [63:0] RL_TABLE_INV = 64'h28_24_20_1c_16_10_0c_06;
  localparam logic [63:0] RTP_TABLE = 64'h10_0e_0c_0a_08_08_08_08;
  localparam logic [63:0] WL_TABLE_A = 64'h12_10_0e_0c_0a_08_06_04;
  localparam logic [63:0] WL_TABLE_B = 64'h22_1e_1a_16_12_0c_08_04;
  localparam logic [7:0] BL32_EXTRA = 8'h08;
  localparam logic [4:0] HALF_MASK = 5'h10;
  // Command kinds
  typedef enum logic [2:0] {
    DBL_CMD_NONE = 3'h0, DBL_CMD_REG_WRITE = 3'h1, DBL_CMD_REG_READ = 3'h2,
    DBL_CMD_READ = 3'h3, DBL_CMD_WRITE = 3'h4
  } dbl_cmd_e;
  // Command from the controller
  typedef struct packed {
    dbl_cmd_e kind;
    logic [5:0] addr;
    logic [7:0] data;
    logic [9:0] column;
    logic long_burst;
    logic auto_precharge;
  } dbl_cmd_s;
  // Active operating settings
  typedef struct packed {
    logic [7:0] read_latency;
    logic [7:0] write_latency;
    logic [7:0] read_to_precharge_count;
    logic pullup_calibration_point;
    logic write_postamble_length;
    logic [2:0] pulldown_drive_strength;
    logic read_bus_inversion_enable;
    logic write_bus_inversion_enable;
  } dbl_op_s;
  // Precharge state machine
  typedef enum logic [1:0] {
    DBL_PRE_IDLE = 2'b00, DBL_PRE_WAIT = 2'b01, DBL_PRE_FIRE = 2'b11
  } dbl_pre_e;
endpackage
`default_nettype wire

// *** logic/dbl_mode_regs.sv ***
// Mode-register bank: latency, I/O config, temperature; burst order; auto-precharge
// Function
// - Read bursts rotate on four-word boundary
// - Lowest two column bits forced zero
// - Sixteen-word writes aligned, linear ascending
// - Thirty-two-word writes aligned, from word zero
// - Read latency table without inversion
// - Read latency table with inversion
// - Write latency set A table
// - Write latency set B table
// - Write leveling holds register-write state
// - Writes/reads hit write set-point copy
// - Operate from operating set-point copy
// - Read auto-precharge after read-to-precharge count
// - Long read bursts add eight clocks
// - Write auto-precharge after write-recovery count
// - Read inversion picks table; bit seven writes
// - Repair protection sticky until power-on
// - Protection refuses repair-mode entry write
// - Temperature read clears update flag
// - Temperature write accepts bits six..three
`default_nettype none
module dbl_mode_regs #(
  parameter int BURST_WORDS = 32
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic link_clk_in,
  input wire dbl_pkg::dbl_cmd_s cmd_in,
  input wire logic cmd_valid_in,
  input wire logic write_set_point_select_in,
  input wire logic operating_set_point_select_in,
  input wire logic [7:0] write_recovery_count_in,
  input wire logic [2:0] refresh_rate_in,
  output logic [7:0] read_data_out,
  output logic read_valid_out,
  output dbl_pkg::dbl_op_s op_out,
  output logic write_latency_set_select_out,
  output logic write_leveling_out,
  output logic repair_protection_out,
  output logic repair_mode_entry_out,
  output logic self_refresh_abort_out,
  output logic [1:0] thermal_offset_out,
  output logic [4:0] burst_word_out,
  output logic burst_word_valid_out,
  output logic precharge_out
);
  logic [1:0] link_sync;
  logic link_prev;
  logic link_rise;
  logic [7:0] lat_copy [2];
  logic [7:0] io_copy [2];
  logic [7:0] tr_reg;
  logic [2:0] rate_prev;
  logic is_wr;
  logic is_rd;
  logic [7:0] io_act;
  logic [7:0] lat_act;
  logic [2:0] rl_code;
  logic [2:0] wl_code;
  logic [4:0] base;
  logic [5:0] word_cnt;
  logic [5:0] burst_len;
  logic burst_read;
  logic burst_on;
  logic [7:0] pre_cnt;
  logic ap_flag;
  dbl_pkg::dbl_pre_e pre_state;

  // Link clock is foreign: two flops, then edge detect on the second only
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      link_sync <= 2'b00;
      link_prev <= 1'b0;
    end else begin
      link_sync <= {link_sync[0], link_clk_in};
      link_prev <= link_sync[1];
    end
  end
  assign link_rise = link_sync[1] & ~link_prev;

  // Commands are taken on a sampled link-clock rising edge
  assign is_wr = link_rise & cmd_valid_in & (cmd_in.kind == dbl_pkg::DBL_CMD_REG_WRITE);
  assign is_rd = link_rise & cmd_valid_in & (cmd_in.kind == dbl_pkg::DBL_CMD_REG_READ);

  // Latency and I/O copies; only the write set-point copy changes
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      lat_copy[0] <= dbl_pkg::LATENCY_CONFIG_RESET;
      lat_copy[1] <= dbl_pkg::LATENCY_CONFIG_RESET;
      io_copy[0] <= dbl_pkg::IO_CONFIG_RESET;
      io_copy[1] <= dbl_pkg::IO_CONFIG_RESET;
    end else if (is_wr) begin
      if (cmd_in.addr == dbl_pkg::ADDR_LATENCY_CONFIG) begin
        lat_copy[write_set_point_select_in] <= cmd_in.data;
      end
      if (cmd_in.addr == dbl_pkg::ADDR_IO_CONFIG) begin
        io_copy[write_set_point_select_in] <= cmd_in.data;
      end
    end
  end

  // Repair protection is shared and sticky; reset here stands for power-on
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      repair_protection_out <= 1'b0;
    end else if (is_wr && cmd_in.addr == dbl_pkg::ADDR_IO_CONFIG
                 && cmd_in.data[dbl_pkg::PROT_BIT]) begin
      repair_protection_out <= 1'b1;
    end
  end

  // Temperature register: writable field, sensor rate and update flag
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tr_reg <= 8'h00;
      rate_prev <= 3'h0;
    end else begin
      rate_prev <= refresh_rate_in;
      if (is_wr && cmd_in.addr == dbl_pkg::ADDR_TEMPERATURE_REFRESH) begin
        tr_reg[dbl_pkg::TR_WR_MSB:dbl_pkg::TR_WR_LSB] <=
          cmd_in.data[dbl_pkg::TR_WR_MSB:dbl_pkg::TR_WR_LSB];
        if (repair_protection_out) begin
          tr_reg[dbl_pkg::TR_REPAIR_BIT] <= 1'b0;
        end
      end
      // Rate change sets the flag; a change wins over the read clear
      if (refresh_rate_in != rate_prev) begin
        tr_reg[dbl_pkg::TR_TUF_BIT] <= 1'b1;
      end else if (is_rd && cmd_in.addr == dbl_pkg::ADDR_TEMPERATURE_REFRESH) begin
        tr_reg[dbl_pkg::TR_TUF_BIT] <= 1'b0;
      end
    end
  end

  // Register read answer, one cycle after the command
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      read_data_out <= 8'h00;
      read_valid_out <= 1'b0;
    end else begin
      read_valid_out <= is_rd;
      if (is_rd) begin
        case (cmd_in.addr)
          dbl_pkg::ADDR_LATENCY_CONFIG: read_data_out <= lat_copy[write_set_point_select_in];
          dbl_pkg::ADDR_IO_CONFIG: read_data_out <= io_copy[write_set_point_select_in];
          dbl_pkg::ADDR_TEMPERATURE_REFRESH:
            read_data_out <= {tr_reg[7:3], refresh_rate_in};
          default: read_data_out <= 8'h00;
        endcase
      end
    end
  end

  // active copy from operating set point
  assign lat_act = lat_copy[operating_set_point_select_in];
  assign io_act = io_copy[operating_set_point_select_in];
  assign rl_code = lat_act[dbl_pkg::RL_LSB +: 3];
  assign wl_code = lat_act[dbl_pkg::WL_LSB +: 3];

  // Decoded operating settings registered for clean outputs
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      op_out <= '0;
    end else begin
      if (io_act[dbl_pkg::RDBI_BIT]) begin
        op_out.read_latency <= dbl_pkg::RL_TABLE_INV[rl_code*8 +: 8];
      end else begin
        op_out.read_latency <= dbl_pkg::RL_TABLE_PLAIN[rl_code*8 +: 8];
      end
      op_out.read_to_precharge_count <= dbl_pkg::RTP_TABLE[rl_code*8 +: 8];
      if (lat_act[dbl_pkg::WLS_BIT]) begin
        op_out.write_latency <= dbl_pkg::WL_TABLE_B[wl_code*8 +: 8];
      end else begin
        op_out.write_latency <= dbl_pkg::WL_TABLE_A[wl_code*8 +: 8];
      end
      op_out.pullup_calibration_point <= io_act[dbl_pkg::PUCAL_BIT];
      op_out.write_postamble_length <= io_act[dbl_pkg::WRPST_BIT];
      op_out.pulldown_drive_strength <= io_act[dbl_pkg::PULLDOWN_DRIVE_STRENGTH_LSB +: 3];
      op_out.read_bus_inversion_enable <= io_act[dbl_pkg::RDBI_BIT];
      op_out.write_bus_inversion_enable <= io_act[dbl_pkg::WDBI_BIT];
    end
  end

  // Loose control bits
  assign write_latency_set_select_out = lat_act[dbl_pkg::WLS_BIT];
  assign write_leveling_out = lat_act[dbl_pkg::WRLEV_BIT];
  assign repair_mode_entry_out = tr_reg[dbl_pkg::TR_REPAIR_BIT];
  assign self_refresh_abort_out = tr_reg[3];
  assign thermal_offset_out = tr_reg[6:5];

  // Burst word sequencer, one word per link-clock edge
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      burst_on <= 1'b0;
      burst_read <= 1'b0;
      base <= 5'h00;
      word_cnt <= 6'h00;
      burst_len <= 6'h00;
    end else if (!burst_on) begin
      // Data commands ignored while leveling, as controller must not send them
      if (link_rise && cmd_valid_in && !write_leveling_out &&
          (cmd_in.kind == dbl_pkg::DBL_CMD_READ || cmd_in.kind == dbl_pkg::DBL_CMD_WRITE)) begin
        burst_on <= 1'b1;
        burst_read <= (cmd_in.kind == dbl_pkg::DBL_CMD_READ);
        word_cnt <= 6'h00;
        burst_len <= cmd_in.long_burst ? 6'(BURST_WORDS) : 6'(BURST_WORDS / 2);
        if (cmd_in.kind == dbl_pkg::DBL_CMD_READ) begin
          base <= {cmd_in.long_burst & cmd_in.column[4], cmd_in.column[3:2], 2'b00};
        end else begin
          // aligned linear writes; C3:C2 assumed zero
          base <= 5'h00;
        end
      end
    end else if (link_rise) begin
      word_cnt <= word_cnt + 6'h01;
      if (word_cnt == burst_len - 6'h01) begin
        burst_on <= 1'b0;
      end
    end
  end

  // rotate inside sixteen-word half, then swap half
  always_comb begin
    if (burst_read) begin
      burst_word_out = {base[4] ^ word_cnt[4], 4'(base[3:0] + word_cnt[3:0])};
    end else begin
      burst_word_out = word_cnt[4:0];
    end
  end
  assign burst_word_valid_out = burst_on;

  // Auto-precharge timer, armed at the end of the burst
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pre_state <= dbl_pkg::DBL_PRE_IDLE;
      pre_cnt <= 8'h00;
      precharge_out <= 1'b0;
    end else begin
      precharge_out <= 1'b0;
      case (pre_state)
        dbl_pkg::DBL_PRE_IDLE: begin
          if (burst_on && link_rise && word_cnt == burst_len - 6'h01 && ap_flag) begin
            pre_state <= dbl_pkg::DBL_PRE_WAIT;
            if (burst_read) begin
              pre_cnt <= op_out.read_to_precharge_count +
                         (burst_len == 6'(BURST_WORDS) ? dbl_pkg::BL32_EXTRA : 8'h00);
            end else begin
              pre_cnt <= write_recovery_count_in;
            end
          end
        end
        dbl_pkg::DBL_PRE_WAIT: begin
          if (link_rise) begin
            pre_cnt <= pre_cnt - 8'h01;
            if (pre_cnt <= 8'h01) begin
              pre_state <= dbl_pkg::DBL_PRE_FIRE;
            end
          end
        end
        dbl_pkg::DBL_PRE_FIRE: begin
          precharge_out <= 1'b1;
          pre_state <= dbl_pkg::DBL_PRE_IDLE;
        end
        default: pre_state <= dbl_pkg::DBL_PRE_IDLE;
      endcase
    end
  end

  // Auto-precharge request latched with the burst
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ap_flag <= 1'b0;
    end else if (!burst_on && link_rise && cmd_valid_in) begin
      ap_flag <= cmd_in.auto_precharge;
    end
  end
endmodule
`default_nettype wire

// *** bench/dbl_ctrl_model.sv ***
// Behavioural controller model: link clock and command pins
`default_nettype none
module dbl_ctrl_model (
  input wire logic clk_in,
  output logic link_clk_out,
  output dbl_pkg::dbl_cmd_s cmd_out,
  output logic cmd_valid_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    link_clk_out = 1'b0;
    cmd_out = '0;
    cmd_valid_out = 1'b0;
  end
  // One link period is eight system clocks; clock stands low between calls
  task automatic send(input dbl_pkg::dbl_cmd_s c, input logic v);
    dbl_pkg::dbl_cmd_s k;
    k = c;
    if (k.kind == dbl_pkg::DBL_CMD_WRITE) begin
      k.column[3:0] = 4'h0;
      if (k.long_burst) k.column[4] = 1'b0;
    end
    @(posedge clk_in);
    link_clk_out <= 1'b1;
    cmd_out <= k;
    cmd_valid_out <= v;
    repeat (4) @(posedge clk_in);
    link_clk_out <= 1'b0;
    repeat (3) @(posedge clk_in);
    // Hold over: scramble so stale values are never trusted
    cmd_out <= dbl_pkg::dbl_cmd_s'(~k);
    cmd_valid_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** bench/dbl_mode_regs_assertions.sv ***
// Port-level checks for the mode-register block
`default_nettype none
module dbl_mode_regs_checker #(
  parameter int BURST_WORDS = 32
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic cmd_valid_in,
  input wire logic read_valid_out,
  input wire dbl_pkg::dbl_op_s op_out,
  input wire logic write_latency_set_select_out,
  input wire logic repair_protection_out,
  input wire logic repair_mode_entry_out,
  input wire logic [1:0] thermal_offset_out,
  input wire logic [4:0] burst_word_out,
  input wire logic burst_word_valid_out,
  input wire logic precharge_out
);
  // Single domain, reset masks every check
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  read_pulse_a: assert property (read_valid_out |=> !read_valid_out)
    else $error("read valid too long");
  pre_pulse_a: assert property (precharge_out |=> !precharge_out)
    else $error("precharge pulse too long");
  prot_sticky_a: assert property (repair_protection_out |=> repair_protection_out)
    else $error("repair protection cleared");
  entry_block_a: assert property (
    $rose(repair_mode_entry_out) |-> !$past(repair_protection_out))
    else $error("repair entry set while protected");
  burst_start_a: assert property (
    $rose(burst_word_valid_out) |-> burst_word_out[1:0] == 2'h0)
    else $error("burst start not aligned");
  burst_step_a: assert property (
    burst_word_valid_out && $past(burst_word_valid_out) && $changed(burst_word_out)
    |-> burst_word_out[3:0] == $past(burst_word_out[3:0]) + 4'h1)
    else $error("burst word out of order");
  // Decoded settings lag reset by one cycle, so skip the first edge after release
  rtp_plain_a: assert property (!$past(srst_in) && !op_out.read_bus_inversion_enable |->
    op_out.read_to_precharge_count == (op_out.read_latency < 8'h18 ? 8'h08 :
    (op_out.read_latency >> 1) - 8'h02)) else $error("plain read pairing wrong");
  rtp_inv_a: assert property (!$past(srst_in) && op_out.read_bus_inversion_enable |->
    op_out.read_to_precharge_count == (op_out.read_latency < 8'h1c ? 8'h08 :
    (op_out.read_latency >> 1) - 8'h04)) else $error("inverted read pairing wrong");
  wl_set_a_a: assert property (!$past(srst_in) && !$past(write_latency_set_select_out) |->
    op_out.write_latency inside {8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0e, 8'h10, 8'h12})
    else $error("write latency outside set A");
  wl_set_b_a: assert property (!$past(srst_in) && $past(write_latency_set_select_out) |->
    op_out.write_latency inside {8'h04, 8'h08, 8'h0c, 8'h12, 8'h16, 8'h1a, 8'h1e, 8'h22})
    else $error("write latency outside set B");
  offset_cause_a: assert property ($changed(thermal_offset_out) |-> $past(cmd_valid_in))
    else $error("offset changed without command");
endmodule
bind dbl_mode_regs dbl_mode_regs_checker #(.BURST_WORDS(BURST_WORDS)) u_chk (
  .clk_in(clk_in), .srst_in(srst_in), .cmd_valid_in(cmd_valid_in),
  .read_valid_out(read_valid_out), .op_out(op_out),
  .write_latency_set_select_out(write_latency_set_select_out),
  .repair_protection_out(repair_protection_out), .repair_mode_entry_out(repair_mode_entry_out),
  .thermal_offset_out(thermal_offset_out), .burst_word_out(burst_word_out),
  .burst_word_valid_out(burst_word_valid_out), .precharge_out(precharge_out));
`default_nettype wire

// *** bench/dbl_mode_regs_tb_top.sv ***
// Testbench for the burst order and latency mode-register block
`default_nettype none
module dbl_mode_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic wsps = 1'b0;
  logic osps = 1'b0;
  logic [7:0] wrc = 8'h05;
  logic [2:0] rate = 3'h3;
  logic link_clk, cmd_valid, rvalid, write_latency_set_select, wlev, prot, pentry, sra, bval, pre;
  dbl_pkg::dbl_cmd_s cmd;
  dbl_pkg::dbl_op_s op;
  logic [7:0] rdata;
  logic [1:0] toff;
  logic [4:0] bword;
  int n_mismatch = 0;
  int compares = 0;
  int rises = 0;
  int pre_at = 0;
  int cyc = 0;
  int rla[8] = '{6, 10, 14, 20, 24, 28, 32, 36};
  int rlb[8] = '{6, 12, 16, 22, 28, 32, 36, 40};
  int rtp[8] = '{8, 8, 8, 8, 10, 12, 14, 16};
  int wla[8] = '{4, 6, 8, 10, 12, 14, 16, 18};
  int wlb[8] = '{4, 8, 12, 18, 22, 26, 30, 34};
  always #50 clk_in = ~clk_in;
  dbl_ctrl_model ctl (.clk_in(clk_in), .link_clk_out(link_clk), .cmd_out(cmd),
    .cmd_valid_out(cmd_valid));
  dbl_mode_regs #(.BURST_WORDS(32)) DUT (.clk_in(clk_in), .srst_in(srst_in),
    .link_clk_in(link_clk), .cmd_in(cmd), .cmd_valid_in(cmd_valid),
    .write_set_point_select_in(wsps), .operating_set_point_select_in(osps),
    .write_recovery_count_in(wrc), .refresh_rate_in(rate), .read_data_out(rdata),
    .read_valid_out(rvalid), .op_out(op), .write_latency_set_select_out(write_latency_set_select),
    .write_leveling_out(wlev), .repair_protection_out(prot), .repair_mode_entry_out(pentry),
    .self_refresh_abort_out(sra), .thermal_offset_out(toff), .burst_word_out(bword),
    .burst_word_valid_out(bval), .precharge_out(pre));
  // Link rise count tells when the precharge pulse landed; hang guard
  always @(posedge link_clk) rises++;
  always @(posedge clk_in) begin
    cyc++;
    if (pre === 1'b1) pre_at = rises;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      n_mismatch++;
    end
  endtask
  task automatic cmd_op(input dbl_pkg::dbl_cmd_e k, input logic [5:0] a, input logic [7:0] d,
      input logic [9:0] col = 10'h000, input logic lng = 1'b0, input logic ap = 1'b0);
    ctl.send('{kind: k, addr: a, data: d, column: col, long_burst: lng, auto_precharge: ap}, 1'b1);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    cmd_op(dbl_pkg::DBL_CMD_REG_WRITE, a, d);
  endtask
  task automatic rd(input logic [5:0] a);
    cmd_op(dbl_pkg::DBL_CMD_REG_READ, a, 8'h00);
  endtask
  task automatic tick();
    ctl.send(dbl_pkg::dbl_cmd_s'(0), 1'b0);
    #1;
  endtask
  task automatic t_setpoint();
    chk("pucal", 8'h01, {7'h00, op.pullup_calibration_point});
    chk("pulldown_drive_strength", 8'h06, {5'h00, op.pulldown_drive_strength});
    @(posedge clk_in) wsps <= 1'b1;
    wr(6'h02, 8'h3f);
    wr(6'h05, 8'hff);
    chk("inactive", 8'h06, op.read_latency);
    @(posedge clk_in) osps <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    chk("active rl", 8'h24, op.read_latency);
    chk("active wl", 8'h12, op.write_latency);
    @(posedge clk_in) begin
      wsps <= 1'b0;
      osps <= 1'b0;
    end
  endtask
  task automatic t_tables();
    for (int v = 0; v < 2; v++) begin
      wr(6'h03, {v[0], v[0], 6'h31});
      chk("wdbi", v[7:0], {7'h00, op.write_bus_inversion_enable});
      for (int i = 0; i < 8; i++) begin
        wr(6'h02, {1'b0, v[0], i[2:0], i[2:0]});
        chk("rl", 8'(v ? rlb[i] : rla[i]), op.read_latency);
        chk("rtp", 8'(rtp[i]), op.read_to_precharge_count);
        chk("wl", 8'(v ? wlb[i] : wla[i]), op.write_latency);
        chk("wls", v[7:0], {7'h00, write_latency_set_select});
      end
    end
    wr(6'h03, 8'h31);
    wr(6'h02, 8'h00);
  endtask
  task automatic t_read();
    logic [4:0] k;
    int last;
    cmd_op(dbl_pkg::DBL_CMD_READ, 6'h00, 8'h00, 10'h01f, 1'b1, 1'b1);
    for (int i = 0; i < 32; i++) begin
      k = i[4:0];
      if (i > 0) tick();
      chk("rword", {3'h0, ~k[4], 4'hc + k[3:0]}, {3'h0, bword});
    end
    last = rises;
    repeat (20) tick();
    // Burst ends one link edge after the last word shows; count starts there
    chk("rpre", 8'(last + 17), 8'(pre_at));
  endtask
  task automatic t_write();
    int last;
    for (int l = 0; l < 2; l++) begin
      cmd_op(dbl_pkg::DBL_CMD_WRITE, 6'h00, 8'h00, 10'h3fc, l[0], 1'b1);
      for (int i = 0; i < 16 + 16 * l; i++) begin
        if (i > 0) tick();
        chk("wword", 8'(i), {3'h0, bword});
      end
      last = rises;
      repeat (8) tick();
      chk("wpre", 8'(last + 6), 8'(pre_at));
    end
  endtask
  task automatic t_level();
    wr(6'h02, 8'h80);
    chk("wlev", 8'h01, {7'h00, wlev});
    cmd_op(dbl_pkg::DBL_CMD_READ, 6'h00, 8'h00);
    chk("refused", 8'h00, {7'h00, bval});
    wr(6'h02, 8'h00);
    chk("wlev off", 8'h00, {7'h00, wlev});
  endtask
  task automatic t_temp();
    @(posedge clk_in) rate <= 3'h1;
    rd(6'h04);
    chk("tuf set", 8'h81, rdata);
    rd(6'h04);
    chk("tuf clr", 8'h01, rdata);
    wr(6'h04, 8'hdf);
    rd(6'h04);
    chk("temp wr", 8'h59, rdata);
    chk("offset", 8'h02, {6'h00, toff});
    chk("self_refresh_abort", 8'h01, {7'h00, sra});
    chk("entry", 8'h01, {7'h00, pentry});
    wr(6'h04, 8'h00);
    wr(6'h03, 8'h35);
    wr(6'h04, 8'h10);
    chk("blocked", 8'h00, {7'h00, pentry});
    wr(6'h03, 8'h31);
    chk("sticky", 8'h01, {7'h00, prot});
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence after a three-cycle reset
  initial begin
    repeat (3) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    t_setpoint();
    t_tables();
    t_read();
    t_write();
    t_level();
    t_temp();
    stop_test();
  end
endmodule
`default_nettype wire
